// file: rtl/cgsm_ctrl_map.sv
// decodes the register bank into the analog control levels
`timescale 1ns/1ps
module cgsm_ctrl_map
  import cgsm_pkg::*;
(
  input  wire cgsm_regs_t regs_in,    // register contents
  input  wire logic [1:0] latched_in, // latched strap spread code
  input  wire logic [5:0] pair_req_n_in, // active-low enable pins
  output cgsm_ctrl_t      ctrl_out    // decoded controls
);
  always_comb begin
    ctrl_out = '0;
    // a cleared enable bit forces the pair low whatever its pin says
    ctrl_out.pair_en   = {regs_in.oe[7:6], regs_in.oe[4:2], regs_in.oe[0]}
                         & ~pair_req_n_in;
    ctrl_out.pair_fast = {regs_in.slew[7:6], regs_in.slew[4:2], regs_in.slew[0]};
    // override bit hands the spread amount to the software field
    if (regs_in.spread[CGSM_SPREAD_SW_BIT]) begin
      ctrl_out.spread_amount = regs_in.spread[CGSM_SPREAD_SW_HI:CGSM_SPREAD_SW_LO];
    end else begin
      ctrl_out.spread_amount = latched_in;
    end
    ctrl_out.amplitude = regs_in.spread[1:0];
    ctrl_out.ref_slew  = regs_in.refc[CGSM_REF_SLEW_HI:CGSM_REF_SLEW_LO];
    ctrl_out.ref_wake  = regs_in.refc[CGSM_REF_WAKE_BIT];
    ctrl_out.ref_en    = regs_in.refc[CGSM_REF_OE_BIT];
  end
endmodule // cgsm_ctrl_map

// file: rtl/cgsm_pin_sync.sv
// two-flop synchroniser with edge flags for one bus line
`timescale 1ns/1ps
module cgsm_pin_sync
  import cgsm_pkg::*;
(
  input  wire logic clk_in,   // system clock
  input  wire logic rst_in,   // async reset, high
  input  wire logic ce_in,    // clock enable
  input  wire logic pin_in,   // raw line level
  output logic      level_out,// filtered level
  output logic      rise_out, // one-cycle rising flag
  output logic      fall_out  // one-cycle falling flag
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  // idle bus level is high, so reset to high to avoid a false edge
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end else if (ce_in) begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level_out = sync_q;
  assign rise_out  = sync_q & ~last_q;
  assign fall_out  = ~sync_q & last_q;
endmodule // cgsm_pin_sync

// file: rtl/cgsm_pkg.sv
// package: register map, field layout, reset values and bus constants for the clock generator control block
package cgsm_pkg;

  localparam logic [7:0] CGSM_IDX_OE      = 8'h00;
  localparam logic [7:0] CGSM_IDX_SPREAD  = 8'h01;
  localparam logic [7:0] CGSM_IDX_SLEW    = 8'h02;
  localparam logic [7:0] CGSM_IDX_REF     = 8'h03;
  localparam logic [7:0] CGSM_IDX_RSVD4   = 8'h04;
  localparam logic [7:0] CGSM_IDX_REVVEND = 8'h05;
  localparam logic [7:0] CGSM_IDX_PART    = 8'h06;
  localparam logic [7:0] CGSM_IDX_RDLEN   = 8'h07;

  // writable bit masks; everything else is fixed
  localparam logic [7:0] CGSM_OE_MASK     = 8'hdd;
  localparam logic [7:0] CGSM_SPREAD_MASK = 8'h3b;
  localparam logic [7:0] CGSM_REF_MASK    = 8'hf0;
  localparam logic [7:0] CGSM_RDLEN_MASK  = 8'h1f;

  localparam logic [7:0] CGSM_OE_RST      = 8'hdd;
  localparam logic [7:0] CGSM_SPREAD_RST  = 8'h06;
  localparam logic [7:0] CGSM_SLEW_RST    = 8'hdd;
  localparam logic [7:0] CGSM_REF_RST     = 8'h5f;
  localparam logic [7:0] CGSM_RDLEN_RST   = 8'h08;
  localparam logic [7:0] CGSM_RSVD_VAL    = 8'h00;

  localparam int CGSM_SPREAD_SW_BIT = 5;
  localparam int CGSM_SPREAD_SW_HI  = 4;
  localparam int CGSM_SPREAD_SW_LO  = 3;
  localparam int CGSM_REF_SLEW_HI   = 7;
  localparam int CGSM_REF_SLEW_LO   = 6;
  localparam int CGSM_REF_WAKE_BIT  = 5;
  localparam int CGSM_REF_OE_BIT    = 4;

  localparam logic [1:0] CGSM_SPREAD_LOW  = 2'h0;
  localparam logic [1:0] CGSM_SPREAD_MID  = 2'h1;
  localparam logic [1:0] CGSM_SPREAD_HIGH = 2'h3;

  // bus address bits 7:1; strap picks one of two
  localparam logic [6:0] CGSM_ADDR_STRAP0 = 7'h68;
  localparam logic [6:0] CGSM_ADDR_STRAP1 = 7'h6a;

  // identity nibbles and codes: values arbitrary
  localparam logic [3:0] CGSM_REV_CODE    = 4'h3;
  localparam logic [3:0] CGSM_VENDOR_CODE = 4'h5;
  localparam logic [1:0] CGSM_PART_TYPE   = 2'h2;
  localparam logic [5:0] CGSM_PART_CODE   = 6'h2a;

  // 400 kHz bus against a 5 ns clock: 500 cycles a bit, far above the 2-cycle filter
  localparam int CGSM_CLK_HZ     = 200_000_000;
  localparam int CGSM_BUS_MAX_HZ = 400_000;
  localparam int CGSM_BIT_CYCLES = CGSM_CLK_HZ / CGSM_BUS_MAX_HZ;

  typedef enum logic [1:0] {
    CGSM_TRI_LOW,
    CGSM_TRI_MID,
    CGSM_TRI_HIGH
  } cgsm_tri_t;

  typedef struct packed {
    logic [7:0] oe;
    logic [7:0] spread;
    logic [7:0] slew;
    logic [7:0] refc;
    logic [7:0] rdlen;
  } cgsm_regs_t;

  typedef struct packed {
    logic [5:0] pair_en;
    logic [5:0] pair_fast;
    logic [1:0] spread_amount;
    logic [1:0] amplitude;
    logic [1:0] ref_slew;
    logic       ref_wake;
    logic       ref_en;
  } cgsm_ctrl_t;

endpackage

// file: rtl/cgsm_smbus_target.sv
// bus target and control register bank of the clock generator
`timescale 1ns/1ps
//
// Operation
// - block write: address, index, count, data, acked
// - written bytes land at consecutive indices
// - block read returns count then data
// - bus address chosen by latched strap
// - index 0 holds six output enables
// - cleared enable forces pair low
// - index 1 bits 7:6 show latched spread
// - index 1 bit 5 selects software spread
// - software spread field coding, default off
// - amplitude field resets to 0.8 V code
// - index 2 per-output slew, reset fast
// - index 3 reference slew, default slow
// - reference wake and enable bits
// - index 5 revision and vendor, fixed
// - index 6 part type and code, fixed
// - index 7 read length, resets to 8
// - works at bus rates to 400 kHz
module cgsm_smbus_target
  import cgsm_pkg::*;
(
  input  wire logic       clk_in,          // 200 MHz system clock
  input  wire logic       rst_in,          // async power-on reset, high
  input  wire logic       ce_in,           // clock enable, freezes all state
  input  wire logic       power_good_in,   // power good; first rise latches straps
  input  wire logic       address_select_strap_in, // address strap level
  input  wire cgsm_tri_t  spread_strap_in, // tri-level spread strap
  input  wire logic [5:0] pair_req_n_in,   // active-low pair enable pins
  input  wire logic       scl_in,          // bus clock line
  input  wire logic       sda_in,          // bus data line level
  output logic            sda_oe_out,      // high pulls data line low
  output logic            sda_out,         // data drive level, always low
  output cgsm_ctrl_t      ctrl_out,        // decoded analog controls
  output logic            busy_out         // transfer addressed to us in progress
);

  typedef enum logic [2:0] {
    CGSM_IDLE,
    CGSM_ADDR,
    CGSM_ACK,
    CGSM_RXBYTE,
    CGSM_TXBYTE,
    CGSM_TXACK,
    CGSM_WAIT
  } cgsm_state_t;

  typedef enum logic [1:0] {
    CGSM_PH_INDEX,
    CGSM_PH_COUNT,
    CGSM_PH_DATA
  } cgsm_phase_t;

  logic        scl_lvl, scl_rise, scl_fall;
  logic        sda_lvl, sda_rise, sda_fall;
  logic        start_ev, stop_ev;

  cgsm_state_t state_q;
  cgsm_phase_t phase_q;
  logic [7:0]  shift_q;
  logic [2:0]  bitcnt_q;
  logic        reading_q;
  logic        nack_next_q;
  logic        first_tx_q;
  logic [7:0]  index_q;
  logic [7:0]  count_q;
  logic [7:0]  txleft_q;
  logic        drive_q;
  logic        latched_q;
  logic        addr_strap_q;
  logic [1:0]  spread_latch_q;
  cgsm_regs_t  regs_q;
  cgsm_ctrl_t  ctrl_d;
  cgsm_ctrl_t  ctrl_q;
  logic        wr_en;
  logic [7:0]  rd_data;
  logic [6:0]  my_addr;
  logic        busy_d;

  cgsm_pin_sync u_scl_sync (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .ce_in     (ce_in),
    .pin_in    (scl_in),
    .level_out (scl_lvl),
    .rise_out  (scl_rise),
    .fall_out  (scl_fall)
  );

  cgsm_pin_sync u_sda_sync (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .ce_in     (ce_in),
    .pin_in    (sda_in),
    .level_out (sda_lvl),
    .rise_out  (sda_rise),
    .fall_out  (sda_fall)
  );

  // data moving while the clock is high marks start and stop
  assign start_ev = sda_fall & scl_lvl;
  assign stop_ev  = sda_rise & scl_lvl;

  // straps are taken once, at the first rise of power good
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      latched_q      <= 1'b0;
      addr_strap_q   <= 1'b0;
      spread_latch_q <= CGSM_SPREAD_LOW;
    end else if (ce_in && !latched_q && power_good_in) begin
      latched_q    <= 1'b1;
      addr_strap_q <= address_select_strap_in;
      case (spread_strap_in)
        CGSM_TRI_LOW:  spread_latch_q <= CGSM_SPREAD_LOW;
        CGSM_TRI_MID:  spread_latch_q <= CGSM_SPREAD_MID;
        CGSM_TRI_HIGH: spread_latch_q <= CGSM_SPREAD_HIGH;
        default:       spread_latch_q <= CGSM_SPREAD_LOW;
      endcase
    end
  end

  // strap is taken once, so a pin change later cannot move the address mid-transfer
  assign my_addr = addr_strap_q ? CGSM_ADDR_STRAP1 : CGSM_ADDR_STRAP0;

  // read mux; fixed bytes come from constants so writes cannot touch them
  always_comb begin
    case (index_q)
      CGSM_IDX_OE:      rd_data = regs_q.oe;
      CGSM_IDX_SPREAD:  rd_data = {spread_latch_q, regs_q.spread[CGSM_SPREAD_SW_BIT:0]};
      CGSM_IDX_SLEW:    rd_data = regs_q.slew;
      CGSM_IDX_REF:     rd_data = regs_q.refc;
      CGSM_IDX_REVVEND: rd_data = {CGSM_REV_CODE, CGSM_VENDOR_CODE};
      CGSM_IDX_PART:    rd_data = {CGSM_PART_TYPE, CGSM_PART_CODE};
      CGSM_IDX_RDLEN:   rd_data = regs_q.rdlen;
      default:          rd_data = CGSM_RSVD_VAL;
    endcase
  end

  // a data byte is complete on the eighth clock rise of the write phase
  // bytes past the count are acked but dropped, so a long write cannot spill over
  assign wr_en = (state_q == CGSM_RXBYTE) && scl_rise && (bitcnt_q == 3'h7)
                 && (phase_q == CGSM_PH_DATA) && (count_q != 8'h00);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      regs_q.oe     <= CGSM_OE_RST;
      regs_q.spread <= CGSM_SPREAD_RST;
      regs_q.slew   <= CGSM_SLEW_RST;
      regs_q.refc   <= CGSM_REF_RST;
      regs_q.rdlen  <= CGSM_RDLEN_RST;
    end else if (ce_in && wr_en) begin
      // reserved bits keep their fixed values through masked merge
      case (index_q)
        CGSM_IDX_OE: regs_q.oe <= ({shift_q[6:0], sda_lvl} & CGSM_OE_MASK)
                                  | (CGSM_OE_RST & ~CGSM_OE_MASK);
        CGSM_IDX_SPREAD: regs_q.spread <= ({shift_q[6:0], sda_lvl} & CGSM_SPREAD_MASK)
                                  | (CGSM_SPREAD_RST & ~CGSM_SPREAD_MASK);
        CGSM_IDX_SLEW: regs_q.slew <= ({shift_q[6:0], sda_lvl} & CGSM_OE_MASK)
                                  | (CGSM_SLEW_RST & ~CGSM_OE_MASK);
        CGSM_IDX_REF: regs_q.refc <= ({shift_q[6:0], sda_lvl} & CGSM_REF_MASK)
                                  | (CGSM_REF_RST & ~CGSM_REF_MASK);
        CGSM_IDX_RDLEN: regs_q.rdlen <= {shift_q[6:0], sda_lvl} & CGSM_RDLEN_MASK;
        default: regs_q.rdlen <= regs_q.rdlen;
      endcase
    end
  end

  // bit engine: samples on clock rise, changes the data line on clock fall
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q     <= CGSM_IDLE;
      phase_q     <= CGSM_PH_INDEX;
      shift_q     <= 8'h00;
      bitcnt_q    <= 3'h0;
      reading_q   <= 1'b0;
      nack_next_q <= 1'b0;
      first_tx_q  <= 1'b0;
      index_q     <= 8'h00;
      count_q     <= 8'h00;
      txleft_q    <= 8'h00;
      drive_q     <= 1'b0;
    end else if (ce_in) begin
      if (stop_ev) begin
        state_q <= CGSM_IDLE;
        drive_q <= 1'b0;
      end else if (start_ev) begin
        // plain or repeated start; index survives for the read that follows
        // a start in mid-byte just restarts address matching
        state_q  <= CGSM_ADDR;
        bitcnt_q <= 3'h0;
        drive_q  <= 1'b0;
      end else begin
        case (state_q)
          CGSM_IDLE: drive_q <= 1'b0;
          CGSM_ADDR: begin
            if (scl_rise) begin
              shift_q  <= {shift_q[6:0], sda_lvl};
              bitcnt_q <= bitcnt_q + 3'h1;
              if (bitcnt_q == 3'h7) begin
                if (shift_q[6:0] == my_addr) begin
                  reading_q  <= sda_lvl;
                  nack_next_q <= 1'b0;
                  first_tx_q <= 1'b1;
                  phase_q    <= CGSM_PH_INDEX;
                  state_q    <= CGSM_ACK;
                end else begin
                  state_q <= CGSM_WAIT;
                end
              end
            end
          end
          CGSM_ACK: begin
            // ack slot: drive low from the fall after the eighth bit to the next fall
            if (scl_fall && !drive_q) begin
              drive_q <= 1'b1;
            end else if (scl_fall && drive_q) begin
              drive_q  <= 1'b0;
              bitcnt_q <= 3'h0;
              if (reading_q) begin
                // first byte sent is the count, then data from the index
                // the count is the live length field, so a fresh write applies at once
                shift_q  <= first_tx_q ? regs_q.rdlen : rd_data;
                txleft_q <= regs_q.rdlen;
                state_q  <= CGSM_TXBYTE;
                drive_q  <= first_tx_q ? ~regs_q.rdlen[7] : ~rd_data[7];
              end else begin
                state_q <= CGSM_RXBYTE;
              end
            end
          end
          CGSM_RXBYTE: begin
            if (scl_rise) begin
              shift_q  <= {shift_q[6:0], sda_lvl};
              bitcnt_q <= bitcnt_q + 3'h1;
              if (bitcnt_q == 3'h7) begin
                state_q <= CGSM_ACK;
                case (phase_q)
                  CGSM_PH_INDEX: begin
                    index_q <= {shift_q[6:0], sda_lvl};
                    phase_q <= CGSM_PH_COUNT;
                  end
                  CGSM_PH_COUNT: begin
                    count_q <= {shift_q[6:0], sda_lvl};
                    phase_q <= CGSM_PH_DATA;
                  end
                  default: begin
                    if (count_q != 8'h00) begin
                      count_q <= count_q - 8'h01;
                      index_q <= index_q + 8'h01;
                    end
                  end
                endcase
              end
            end
          end
          CGSM_TXBYTE: begin
            if (scl_fall) begin
              bitcnt_q <= bitcnt_q + 3'h1;
              if (bitcnt_q == 3'h7) begin
                drive_q <= 1'b0;
                state_q <= CGSM_TXACK;
                if (first_tx_q) begin
                  first_tx_q <= 1'b0;
                end else begin
                  index_q  <= index_q + 8'h01;
                  txleft_q <= txleft_q - 8'h01;
                end
              end else begin
                // open-drain: drive low only for zero bits
                drive_q <= ~shift_q[3'h6 - bitcnt_q];
              end
            end
          end
          CGSM_TXACK: begin
            if (scl_rise) begin
              nack_next_q <= sda_lvl;
            end else if (scl_fall) begin
              bitcnt_q <= 3'h0;
              // host not-ack ends the read; a stop then follows
              // acks past the count find the line released and read ones
              if (nack_next_q || txleft_q == 8'h00) begin
                state_q <= CGSM_WAIT;
                drive_q <= 1'b0;
              end else begin
                shift_q <= rd_data;
                drive_q <= ~rd_data[7];
                state_q <= CGSM_TXBYTE;
              end
            end
          end
          CGSM_WAIT: drive_q <= 1'b0;
          default: begin
            state_q <= CGSM_IDLE;
            drive_q <= 1'b0;
          end
        endcase
      end
    end
  end

  cgsm_ctrl_map u_map (
    .regs_in       (regs_q),
    .latched_in    (spread_latch_q),
    .pair_req_n_in (pair_req_n_in),
    .ctrl_out      (ctrl_d)
  );

  // busy covers the acknowledged part of a transfer only, not address matching
  always_comb begin
    case (state_q)
      CGSM_ACK, CGSM_RXBYTE,
      CGSM_TXBYTE, CGSM_TXACK: busy_d = 1'b1;
      default:                 busy_d = 1'b0;
    endcase
  end

  // registered outputs; bit period dwarfs the few cycles of latency
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q     <= '0;
      sda_oe_out <= 1'b0;
      busy_out   <= 1'b0;
    end else if (ce_in) begin
      ctrl_q     <= ctrl_d;
      sda_oe_out <= drive_q;
      busy_out   <= busy_d;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sda_out <= 1'b0;
    end else if (ce_in) begin
      sda_out <= 1'b0;
    end
  end

  assign ctrl_out = ctrl_q;

endmodule // cgsm_smbus_target

// file: verif/cgsm_host_model.sv
// bus host model: start, stop and byte transfers on the open-drain pair
`timescale 1ns/1ps
module cgsm_host_model (
  input  wire logic clk_in,   // bench clock
  input  wire logic sda_in,   // resolved data wire
  output logic      scl_out,  // bus clock, idle high
  output logic      pull_out  // high pulls data low
);
  initial begin
    scl_out  = 1'b1;
    pull_out = 1'b0;
  end
  task automatic hw(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // data moves 3 cycles after the clock falls so no false start or stop is seen
  task automatic start();
    hw(3);
    pull_out = 1'b0;
    hw(12);
    scl_out = 1'b1;
    hw(15);
    pull_out = 1'b1;
    hw(15);
    scl_out = 1'b0;
  endtask
  task automatic stop();
    hw(3);
    pull_out = 1'b1;
    hw(12);
    scl_out = 1'b1;
    hw(15);
    pull_out = 1'b0;
    hw(15);
  endtask
  // 30-cycle bit at 5 ns is 150 ns, far faster than 400 kHz
  task automatic bitx(input logic b, output logic r);
    hw(3);
    pull_out = ~b;
    hw(12);
    scl_out = 1'b1;
    hw(8);
    r = sda_in;
    hw(7);
    scl_out = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic hack, output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
    bitx(~hack, a);
    ack = ~a;
  endtask
endmodule  // cgsm_host_model

// file: verif/cgsm_smbus_target_chk.sv
// assertion checker for the bus target, bound to the design top
`timescale 1ns/1ps
module cgsm_smbus_target_chk
  import cgsm_pkg::*;
(
  input wire logic       clk_in,                  // clock
  input wire logic       rst_in,                  // reset
  input wire logic       ce_in,                   // enable
  input wire logic       power_good_in,           // power good
  input wire logic       address_select_strap_in, // strap
  input wire cgsm_tri_t  spread_strap_in,         // strap
  input wire logic [5:0] pair_req_n_in,           // pins
  input wire logic       scl_in,                  // bus clock
  input wire logic       sda_in,                  // bus data
  input wire logic       sda_oe_out,              // data pull
  input wire logic       sda_out,                 // data level
  input wire cgsm_ctrl_t ctrl_out,                // controls
  input wire logic       busy_out                 // busy
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic       scl_q;
  logic [3:0] falls_q;
  // clock falls seen while the data line stays pulled
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_q   <= 1'b1;
      falls_q <= 4'h0;
    end else begin
      scl_q <= scl_in;
      if (!sda_oe_out) begin
        falls_q <= 4'h0;
      end else if (scl_q && !scl_in && falls_q != 4'hf) begin
        falls_q <= falls_q + 4'h1;
      end
    end
  end
  sequence stop_seq;
    scl_in && $rose(sda_in);
  endsequence
  sequence ack_rise;
    $rose(sda_oe_out);
  endsequence
  AST_DRIVE_LOW_ONLY: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  AST_OE_MOVES_SCL_LOW: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("data drive changed while clock high");
  AST_ACK_HOLDS: assert property (ack_rise |=> sda_oe_out [*8])
    else $error("data drive released too early");
  AST_PAIR_FORCED_LOW: assert property ($stable(pair_req_n_in) [*6] |-> (ctrl_out.pair_en & pair_req_n_in) == 6'h00)
    else $error("pair enabled against its pin");
  AST_CTRL_RESET: assert property ($fell(rst_in) |-> ##2 (ctrl_out.pair_fast == 6'h3f && ctrl_out.amplitude == 2'h2 && ctrl_out.ref_slew == 2'h1 && !ctrl_out.ref_wake && ctrl_out.ref_en))
    else $error("controls not at reset values");
  AST_STOP_ENDS_BUSY: assert property (stop_seq |-> ##[1:8] !busy_out)
    else $error("busy held after stop");
  AST_ACK_WHEN_ADDRESSED: assert property (ack_rise |-> ##[0:4] busy_out)
    else $error("drive without address match");
  AST_OE_RELEASES: assert property (falls_q <= 4'h8)
    else $error("data line held past a byte");
endmodule  // cgsm_smbus_target_chk

bind cgsm_smbus_target cgsm_smbus_target_chk u_chk (
  .clk_in, .rst_in, .ce_in, .power_good_in, .address_select_strap_in, .spread_strap_in,
  .pair_req_n_in, .scl_in, .sda_in, .sda_oe_out, .sda_out, .ctrl_out, .busy_out);

// file: verif/cgsm_smbus_target_test.sv
// self-checking bench: block writes and reads against a register model
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module cgsm_smbus_target_test;
  import cgsm_pkg::*;
  logic       clk_in = 1'b0;
  logic       rst_in = 1'b1;
  logic       ce     = 1'b1;
  logic       pg     = 1'b0;
  logic       strap  = 1'b0;
  cgsm_tri_t  sstrap = CGSM_TRI_LOW;
  logic [5:0] req_n  = 6'h00;
  logic       scl, pull, sda_oe, sda_o, busy, sda;
  cgsm_ctrl_t ctrl;
  logic [6:0] adr;
  logic [1:0] lat;
  logic [7:0] m [8];
  int         num_errors = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  // wired-and data line with pull-up
  assign sda = ~(pull | (sda_oe & ~sda_o));
  cgsm_smbus_target dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .power_good_in(pg),
    .address_select_strap_in(strap), .spread_strap_in(sstrap), .pair_req_n_in(req_n), .scl_in(scl),
    .sda_in(sda), .sda_oe_out(sda_oe), .sda_out(sda_o), .ctrl_out(ctrl), .busy_out(busy));
  cgsm_host_model u_host (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .pull_out(pull));
  initial begin
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 90000) begin
      num_errors++;
      report_and_stop();
    end
  end
  function automatic logic [7:0] msk(input logic [7:0] i);
    case (i)
      8'h00, 8'h02: return 8'hdd;
      8'h01: return 8'h3b;
      8'h03: return 8'hf0;
      8'h07: return 8'h1f;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] mrd(input logic [7:0] i);
    case (i)
      8'h01: return {lat, m[1][5:0]};
      8'h05: return {CGSM_REV_CODE, CGSM_VENDOR_CODE};
      8'h06: return {CGSM_PART_TYPE, CGSM_PART_CODE};
      default: return (i < 8) ? m[i[2:0]] : 8'h00;
    endcase
  endfunction
  function automatic cgsm_ctrl_t ectl();
    cgsm_ctrl_t c;
    c.pair_en       = {m[0][7:6], m[0][4:2], m[0][0]} & ~req_n;
    c.pair_fast     = {m[2][7:6], m[2][4:2], m[2][0]};
    c.spread_amount = m[1][5] ? m[1][4:3] : lat;
    c.amplitude     = m[1][1:0];
    c.ref_slew      = m[3][7:6];
    c.ref_wake      = m[3][5];
    c.ref_en        = m[3][4];
    return c;
  endfunction
  task automatic put(input logic [7:0] d, input logic ea);
    logic [7:0] r;
    logic       a;
    u_host.xfer(d, 1'b0, r, a);
    `CHK(a, ea)
  endtask
  task automatic blk_wr(input logic [7:0] idx, input logic [7:0] q[$]);
    logic [7:0] j;
    u_host.start();
    put({adr, 1'b0}, 1'b1);
    put(idx, 1'b1);
    put(8'(q.size()), 1'b1);
    foreach (q[k]) begin
      put(q[k], 1'b1);
      j = idx + 8'(k);
      if (j < 8) m[j[2:0]] = (m[j[2:0]] & ~msk(j)) | (q[k] & msk(j));
    end
    u_host.stop();
  endtask
  task automatic blk_rd(input logic [7:0] idx);
    logic [7:0] r, n;
    logic       a;
    u_host.start();
    put({adr, 1'b0}, 1'b1);
    put(idx, 1'b1);
    u_host.start();
    put({adr, 1'b1}, 1'b1);
    n = {3'h0, m[7][4:0]};
    u_host.xfer(8'hff, 1'b1, r, a);
    `CHK(r, n)
    for (int k = 0; k < n; k++) begin
      u_host.xfer(8'hff, k < n - 1, r, a);
      `CHK(r, mrd(idx + 8'(k)))
    end
    u_host.stop();
  endtask
  initial begin
    logic [7:0] q[$];
    void'($urandom(32'ha4fa148c));
    for (int s = 0; s < 2; s++) begin
      rst_in = 1'b1;
      pg     = 1'b0;
      strap  = s[0];
      sstrap = s ? CGSM_TRI_HIGH : CGSM_TRI_MID;
      lat    = s ? 2'h3 : 2'h1;
      adr    = s ? CGSM_ADDR_STRAP1 : CGSM_ADDR_STRAP0;
      m      = '{8'hdd, 8'h06, 8'hdd, 8'h5f, 8'h00, 8'h00, 8'h00, 8'h08};
      repeat (12) @(negedge clk_in);
      rst_in = 1'b0;
      repeat (2) @(negedge clk_in);
      pg = 1'b1;
      repeat (8) @(negedge clk_in);
      `CHK(ctrl, ectl())
      blk_rd(8'h00);
      u_host.start();
      put({adr ^ 7'h02, 1'b0}, 1'b0);
      u_host.stop();
      // sweeps every software spread code, amplitude and reference slew code
      for (int k = 0; k < 5; k++) begin
        req_n = 6'($urandom);
        q = {};
        for (int i = 0; i < 8; i++) q.push_back(8'($urandom));
        q[1][5:3] = {k < 4, 2'(k + 3)};
        q[1][1:0] = 2'(k);
        q[3][7:6] = 2'(k);
        q[7]      = {3'($urandom), 5'($urandom_range(8, 1))};
        blk_wr(8'h00, q);
        repeat (20) @(negedge clk_in);
        `CHK(ctrl, ectl())
        // a low clock enable must hold the controls through a pin change
        ce    = 1'b0;
        req_n = ~req_n;
        repeat (4) @(negedge clk_in);
        req_n = ~req_n;
        `CHK(ctrl, ectl())
        ce    = 1'b1;
        blk_rd(8'(k));
        $display("test strap %0d pass %0d done", s, k);
      end
    end
    report_and_stop();
  end
endmodule  // cgsm_smbus_target_test
